// *** logic/spw_pkg.sv ***
// Purpose: Shared constants and types for the sync pulse timing and watchdog prescale block
// Assumes: One peripheral clock, synchronous active-low reset
// Notes:   Register offsets are byte addresses on the simple register port
package spw_pkg;

  localparam int unsigned DATA_WIDTH     = 32;
  localparam int unsigned ADDR_WIDTH     = 12;
  localparam int unsigned PRESCALE_WIDTH = 16;
  localparam int unsigned SYNC_CHANNELS  = 2;

  // Register offsets
  localparam logic [11:0] SYNC_A_PERIOD_OFFSET        = 12'h114;
  localparam logic [11:0] SYNC_B_DELAY_PERIOD_OFFSET  = 12'h118;
  localparam logic [11:0] SYNC_START_DELAY_OFFSET     = 12'h11c;
  localparam logic [11:0] WATCHDOG_TICK_PRESCALE_OFFSET = 12'h200;

  // Field positions of the prescale register
  localparam int unsigned PRESCALE_FIELD_LSB = 0;
  localparam int unsigned PRESCALE_FIELD_MSB = 15;

  // Reset values
  localparam logic [31:0] SYNC_A_PERIOD_RESET       = 32'h0000_0001;
  localparam logic [31:0] SYNC_B_DELAY_PERIOD_RESET = 32'h0000_0000;
  localparam logic [31:0] SYNC_START_DELAY_RESET    = 32'h0000_0000;
  localparam logic [15:0] WATCHDOG_PRESCALE_RESET   = 16'h4e20;

  localparam logic [31:0] READ_ZERO  = 32'h0000_0000;
  localparam logic [31:0] COUNT_ZERO = 32'h0000_0000;
  localparam logic [31:0] COUNT_ONE  = 32'h0000_0001;

  typedef enum logic [1:0] {
    SPW_IDLE       = 2'b00,
    SPW_WAIT_START = 2'b01,
    SPW_RUN        = 2'b10
  } spw_seq_state_type;

endpackage : spw_pkg

// *** logic/spw_pulse_if.sv ***
// Purpose: Carries one sync channel's trigger, width and pulse between modules
// Assumes: All signals on the peripheral clock
// Notes:   The source drives enable, trigger and width; the shaper drives pulse
`timescale 1ns/100ps
interface spw_pulse_if;
  logic        enable;
  logic        trigger;
  logic [31:0] width;
  logic        pulse;

  modport source (output enable, output trigger, output width, input pulse);
  modport shaper (input enable, input trigger, input width, output pulse);
endinterface : spw_pulse_if

// *** logic/spw_pulse_shaper.sv ***
// Purpose: Turns a one-cycle trigger into a sync pulse of programmed width
// Assumes: Trigger is a one-cycle pulse on the peripheral clock
// Notes:   A trigger during a pulse restarts its width count
`timescale 1ns/100ps
module spw_pulse_shaper (
  input  wire logic   clock_in,
  input  wire logic   rst_n_in,
  spw_pulse_if.shaper pulse_port
);

  logic        high;
  logic        next_high;
  logic [31:0] remain;
  logic [31:0] next_remain;

  always_comb begin
    next_high   = high;
    next_remain = remain;
    if (!pulse_port.enable) begin
      // Disable cuts any ongoing pulse short
      next_high   = 1'b0;
      next_remain = spw_pkg::COUNT_ZERO;
    end else if (pulse_port.trigger) begin
      next_high   = 1'b1;
      next_remain = pulse_port.width;
    end else if (high) begin
      if (remain == spw_pkg::COUNT_ZERO) begin
        next_high = 1'b0;
      end else begin
        next_remain = remain - spw_pkg::COUNT_ONE;
      end
    end
  end

  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      high   <= 1'b0;
      remain <= spw_pkg::COUNT_ZERO;
    end else begin
      high   <= next_high;
      remain <= next_remain;
    end
  end

  assign pulse_port.pulse = high;

endmodule : spw_pulse_shaper

// *** logic/spw_wd_prescale.sv ***
// Purpose: Free-running divider producing watchdog ticks
// Assumes: Divide value is stable except when restart is pulsed
// Notes:   A divide value of 0 or 1 ticks every cycle
`timescale 1ns/100ps
module spw_wd_prescale (
  input  wire logic        clock_in,
  input  wire logic        rst_n_in,
  input  wire logic [15:0] divide_in,
  input  wire logic        restart_in,
  output logic             tick_out
);

  logic [15:0] count;
  logic [15:0] next_count;
  logic        tick;
  logic        next_tick;

  // No enable input: ticks run whether or not a watchdog is armed
  always_comb begin
    next_tick  = 1'b0;
    next_count = count + 16'h0001;
    if (restart_in) begin
      next_count = 16'h0000;
    end else if ((divide_in <= 16'h0001) || (count >= (divide_in - 16'h0001))) begin
      next_tick  = 1'b1;
      next_count = 16'h0000;
    end
  end

  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      count <= 16'h0000;
      tick  <= 1'b0;
    end else begin
      count <= next_count;
      tick  <= next_tick;
    end
  end

  assign tick_out = tick;

endmodule : spw_wd_prescale

// *** logic/spw_top.sv ***
// Purpose: Sync pulse timing for two outputs plus the watchdog tick prescaler
// Assumes: Synchronous inputs; register port accesses are single-cycle strobes
//          Sync counts are full 32-bit; the prescale field is 16 bits
// Notes:   Enable, independent select, pulse width and activation are plain inputs
//          A period of zero is reserved; it retriggers every cycle
//          and the output then simply stays high
//          Reads return the word held before a same-cycle write
//
// What this block does
// - Output A rising edges spaced period plus one
// - Dependent mode: B starts delay cycles after A
// - Independent mode: B uses field as own period
// - First sync issued start value plus one after activation
// - One watchdog tick per prescale count cycles
// - Watchdog tick generator runs without any enable
// - Prescale count resets to twenty thousand
// - Period A resets to one, B delay zero
// - Pulse high width plus one, cut on disable
`timescale 1ns/100ps
module spw_top (
  input  wire logic        clock_in,
  input  wire logic        rst_n_in,
  input  wire logic [11:0] reg_addr_in,
  input  wire logic        reg_write_in,
  input  wire logic        reg_read_in,
  input  wire logic [31:0] reg_wdata_in,
  output logic [31:0]      reg_rdata_out,
  input  wire logic        sync_enable_in,
  input  wire logic        sync_b_independent_select_in,
  input  wire logic [31:0] sync_high_width_in,
  input  wire logic        activation_event_in,
  output logic             sync_out_a_out,
  output logic             sync_out_b_out,
  output logic             sync_active_out,
  output logic             wd_tick_out
);

  // Register file state
  logic [31:0] sync_a_period;
  logic [31:0] next_sync_a_period;
  logic [31:0] sync_b_delay_or_period;
  logic [31:0] next_sync_b_delay_or_period;
  logic [31:0] sync_start_delay;
  logic [31:0] next_sync_start_delay;
  logic [15:0] watchdog_tick_prescale;
  logic [15:0] next_watchdog_tick_prescale;
  logic [31:0] read_data;
  logic [31:0] next_read_data;
  logic        prescale_restart;

  // Sequencer state
  spw_pkg::spw_seq_state_type state;
  spw_pkg::spw_seq_state_type next_state;
  logic [31:0] start_count;
  logic [31:0] next_start_count;
  logic [31:0] period_a_count;
  logic [31:0] next_period_a_count;
  logic [31:0] period_b_count;
  logic [31:0] next_period_b_count;

  // Dependent B delay tracking
  logic [31:0] delay_b_count;
  logic [31:0] next_delay_b_count;
  logic        delay_b_pending;
  logic        next_delay_b_pending;

  // Triggers toward the pulse shapers
  logic        first_trigger;
  logic        trigger_a;
  logic        trigger_b;
  logic [1:0]  channel_trigger;
  logic [1:0]  channel_pulse;

  // Register writes and reads
  always_comb begin
    next_sync_a_period          = sync_a_period;
    next_sync_b_delay_or_period = sync_b_delay_or_period;
    next_sync_start_delay       = sync_start_delay;
    next_watchdog_tick_prescale = watchdog_tick_prescale;
    next_read_data              = read_data;
    prescale_restart            = 1'b0;
    if (reg_write_in) begin
      unique case (reg_addr_in)
        spw_pkg::SYNC_A_PERIOD_OFFSET: begin
          next_sync_a_period = reg_wdata_in;
        end
        spw_pkg::SYNC_B_DELAY_PERIOD_OFFSET: begin
          next_sync_b_delay_or_period = reg_wdata_in;
        end
        spw_pkg::SYNC_START_DELAY_OFFSET: begin
          next_sync_start_delay = reg_wdata_in;
        end
        spw_pkg::WATCHDOG_TICK_PRESCALE_OFFSET: begin
          // A write also restarts the divider so the new rate starts clean
          next_watchdog_tick_prescale =
            reg_wdata_in[spw_pkg::PRESCALE_FIELD_MSB:spw_pkg::PRESCALE_FIELD_LSB];
          prescale_restart = 1'b1;
        end
        default: begin
          // Unmapped writes are dropped
        end
      endcase
    end
    // Read uses the current words, so a same-cycle write is not seen yet
    if (reg_read_in) begin
      unique case (reg_addr_in)
        spw_pkg::SYNC_A_PERIOD_OFFSET: begin
          next_read_data = sync_a_period;
        end
        spw_pkg::SYNC_B_DELAY_PERIOD_OFFSET: begin
          next_read_data = sync_b_delay_or_period;
        end
        spw_pkg::SYNC_START_DELAY_OFFSET: begin
          next_read_data = sync_start_delay;
        end
        spw_pkg::WATCHDOG_TICK_PRESCALE_OFFSET: begin
          // Upper half reads as zero
          next_read_data = {16'h0000, watchdog_tick_prescale};
        end
        default: begin
          next_read_data = spw_pkg::READ_ZERO;
        end
      endcase
    end
  end

  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      sync_a_period          <= spw_pkg::SYNC_A_PERIOD_RESET;
      sync_b_delay_or_period <= spw_pkg::SYNC_B_DELAY_PERIOD_RESET;
      // Zero start delay still waits one cycle
      sync_start_delay       <= spw_pkg::SYNC_START_DELAY_RESET;
      watchdog_tick_prescale <= spw_pkg::WATCHDOG_PRESCALE_RESET;
      read_data              <= spw_pkg::READ_ZERO;
    end else begin
      sync_a_period          <= next_sync_a_period;
      sync_b_delay_or_period <= next_sync_b_delay_or_period;
      sync_start_delay       <= next_sync_start_delay;
      watchdog_tick_prescale <= next_watchdog_tick_prescale;
      read_data              <= next_read_data;
    end
  end

  // Read data stays until the next read strobe
  assign reg_rdata_out = read_data;

  // First sync fires when the start delay has run out
  assign first_trigger = (state == spw_pkg::SPW_WAIT_START) &&
                         (start_count == spw_pkg::COUNT_ZERO);

  assign trigger_a = first_trigger ||
                     ((state == spw_pkg::SPW_RUN) &&
                      (period_a_count == spw_pkg::COUNT_ZERO));
  // Trigger A meets enable at the shaper input

  // Trigger for B depends on the mode
  always_comb begin
    if (!sync_enable_in) begin
      // Disable also blocks the zero-delay path
      trigger_b = 1'b0;
    end else if (sync_b_independent_select_in) begin
      trigger_b = first_trigger ||
                  ((state == spw_pkg::SPW_RUN) &&
                   (period_b_count == spw_pkg::COUNT_ZERO));
    end else if (trigger_a && (sync_b_delay_or_period == spw_pkg::COUNT_ZERO)) begin
      // Zero delay: B shares the A trigger edge
      trigger_b = 1'b1;
    end else begin
      trigger_b = delay_b_pending && (delay_b_count == spw_pkg::COUNT_ZERO);
    end
  end

  // Sequencer next state
  always_comb begin
    next_state           = state;
    next_start_count     = start_count;
    next_period_a_count  = period_a_count;
    next_period_b_count  = period_b_count;
    next_delay_b_count   = delay_b_count;
    next_delay_b_pending = delay_b_pending;
    if (!sync_enable_in) begin
      // Everything parks so the next enable starts from the registers
      next_state           = spw_pkg::SPW_IDLE;
      next_start_count     = spw_pkg::COUNT_ZERO;
      next_period_a_count  = spw_pkg::COUNT_ZERO;
      next_period_b_count  = spw_pkg::COUNT_ZERO;
      next_delay_b_count   = spw_pkg::COUNT_ZERO;
      next_delay_b_pending = 1'b0;
    end else begin
      unique case (state)
        spw_pkg::SPW_IDLE: begin
          // Activation is only taken from idle
          if (activation_event_in) begin
            next_state       = spw_pkg::SPW_WAIT_START;
            next_start_count = sync_start_delay;
          end
        end
        spw_pkg::SPW_WAIT_START: begin
          // Count runs from the start value down to zero
          if (start_count == spw_pkg::COUNT_ZERO) begin
            next_state = spw_pkg::SPW_RUN;
          end else begin
            next_start_count = start_count - spw_pkg::COUNT_ONE;
          end
        end
        spw_pkg::SPW_RUN: begin
          // Run holds until enable drops
        end
        default: begin
          // Unused code falls back to idle
          next_state = spw_pkg::SPW_IDLE;
        end
      endcase
      // Period A reloads on each start and counts down only in run
      if (trigger_a) begin
        next_period_a_count = sync_a_period;
      end else if (state == spw_pkg::SPW_RUN) begin
        next_period_a_count = period_a_count - spw_pkg::COUNT_ONE;
      end
      // Switching to independent mode drops a pending B delay
      if (sync_b_independent_select_in) begin
        next_delay_b_pending = 1'b0;
        // Period B reloads on its own trigger
        if (trigger_b) begin
          next_period_b_count = sync_b_delay_or_period;
        end else if (state == spw_pkg::SPW_RUN) begin
          next_period_b_count = period_b_count - spw_pkg::COUNT_ONE;
        end
      end else begin
        // A new A start restarts a pending B delay
        if (trigger_a && (sync_b_delay_or_period != spw_pkg::COUNT_ZERO)) begin
          next_delay_b_pending = 1'b1;
          next_delay_b_count   = sync_b_delay_or_period - spw_pkg::COUNT_ONE;
        end else if (delay_b_pending) begin
          if (delay_b_count == spw_pkg::COUNT_ZERO) begin
            // Expired: B fires in this cycle
            next_delay_b_pending = 1'b0;
          end else begin
            next_delay_b_count = delay_b_count - spw_pkg::COUNT_ONE;
          end
        end
      end
    end
  end

  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      state           <= spw_pkg::SPW_IDLE;
      start_count     <= spw_pkg::COUNT_ZERO;
      period_a_count  <= spw_pkg::COUNT_ZERO;
      period_b_count  <= spw_pkg::COUNT_ZERO;
      delay_b_count   <= spw_pkg::COUNT_ZERO;
      delay_b_pending <= 1'b0;
    end else begin
      state           <= next_state;
      start_count     <= next_start_count;
      period_a_count  <= next_period_a_count;
      period_b_count  <= next_period_b_count;
      delay_b_count   <= next_delay_b_count;
      delay_b_pending <= next_delay_b_pending;
    end
  end

  // Active covers both the start wait and the run
  assign sync_active_out = (state != spw_pkg::SPW_IDLE);

  // One shaper per sync channel
  assign channel_trigger = {trigger_b, trigger_a && sync_enable_in};

  // Shapers share width and enable; only the triggers differ
  spw_pulse_if pulse_bus [spw_pkg::SYNC_CHANNELS] ();

  genvar ch;
  generate
    for (ch = 0; ch < spw_pkg::SYNC_CHANNELS; ch++) begin : g_channel
      assign pulse_bus[ch].enable  = sync_enable_in;
      assign pulse_bus[ch].trigger = channel_trigger[ch];
      assign pulse_bus[ch].width   = sync_high_width_in;
      assign channel_pulse[ch]     = pulse_bus[ch].pulse;

      spw_pulse_shaper u_shaper (
        .clock_in   (clock_in),
        .rst_n_in   (rst_n_in),
        .pulse_port (pulse_bus[ch])
      );
    end
  endgenerate

  // Channel 0 is A, channel 1 is B
  assign sync_out_a_out = channel_pulse[0];
  assign sync_out_b_out = channel_pulse[1];

  // Prescaler is fed from the register alone, never gated
  spw_wd_prescale u_prescale (
    .clock_in   (clock_in),
    .rst_n_in   (rst_n_in),
    .divide_in  (watchdog_tick_prescale),
    .restart_in (prescale_restart),
    .tick_out   (wd_tick_out)
  );

endmodule : spw_top

// *** testbench/spw_top_asserts.sv ***
// Purpose: Port-level checks for the sync timing and watchdog tick block
// Assumes: Register contents are tracked from write strobes on the register port
// Notes:   Any write clears the seen flags, so the gap checks skip the first edge after it
`timescale 1ns/100ps
module spw_chk (
  input wire logic        clock_in,
  input wire logic        rst_n_in,
  input wire logic [11:0] reg_addr_in,
  input wire logic        reg_write_in,
  input wire logic        reg_read_in,
  input wire logic [31:0] reg_wdata_in,
  input wire logic [31:0] reg_rdata_out,
  input wire logic        sync_enable_in,
  input wire logic        sync_b_independent_select_in,
  input wire logic [31:0] sync_high_width_in,
  input wire logic        activation_event_in,
  input wire logic        sync_out_a_out,
  input wire logic        sync_out_b_out,
  input wire logic        sync_active_out,
  input wire logic        wd_tick_out
);
  logic [31:0] per_a, per_b, gap_a, gap_b, high_a;
  logic [16:0] gap_t;
  logic [15:0] pre;
  logic        seen_a, seen_b, seen_t;
  wire         clr_s = !rst_n_in || !sync_enable_in || reg_write_in;
  wire         clr_t = !rst_n_in || reg_write_in;

  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      per_a <= 32'h0000_0001;
      per_b <= 32'h0000_0000;
      pre   <= 16'h4e20;
    end else if (reg_write_in) begin
      if (reg_addr_in == 12'h114) per_a <= reg_wdata_in;
      if (reg_addr_in == 12'h118) per_b <= reg_wdata_in;
      if (reg_addr_in == 12'h200) pre <= reg_wdata_in[15:0];
    end
    gap_a  <= $rose(sync_out_a_out) ? 32'h0000_0001 : gap_a + 32'h0000_0001;
    gap_b  <= $rose(sync_out_b_out) ? 32'h0000_0001 : gap_b + 32'h0000_0001;
    gap_t  <= wd_tick_out ? 17'h0_0001 : gap_t + 17'h0_0001;
    high_a <= sync_out_a_out ? high_a + 32'h0000_0001 : 32'h0000_0000;
    seen_a <= !clr_s && (seen_a || $rose(sync_out_a_out));
    seen_b <= !clr_s && (seen_b || $rose(sync_out_b_out));
    seen_t <= !clr_t && (seen_t || wd_tick_out);
  end

  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!rst_n_in);

  sequence s_arm;
    sync_enable_in && !sync_active_out && activation_event_in;
  endsequence
  sequence s_rise_b_dep;
    $rose(sync_out_b_out) && !sync_b_independent_select_in;
  endsequence

  AST_ARM: assert property (s_arm |=> sync_active_out)
    else $error("activation not taken");
  AST_OFF_IDLE: assert property (!sync_enable_in |=> !sync_active_out)
    else $error("sequencer busy while disabled");
  AST_OFF_LOW: assert property (!sync_enable_in |=> !sync_out_a_out && !sync_out_b_out)
    else $error("sync output high while disabled");
  AST_A_PERIOD: assert property ($rose(sync_out_a_out) && seen_a |-> gap_a == per_a + 1)
    else $error("output a period wrong");
  AST_B_DELAY: assert property (s_rise_b_dep |->
    ($rose(sync_out_a_out) && per_b == 0) || (seen_a && gap_a == per_b))
    else $error("output b delay wrong");
  AST_B_PERIOD: assert property (
    $rose(sync_out_b_out) && sync_b_independent_select_in && seen_b |-> gap_b == per_b + 1)
    else $error("output b period wrong");
  AST_A_WIDTH: assert property (
    $fell(sync_out_a_out) && $past(sync_enable_in) |-> high_a == sync_high_width_in + 1)
    else $error("output a width wrong");
  AST_TICK_GAP: assert property (
    wd_tick_out && seen_t && pre > 16'h0001 |-> gap_t == {1'b0, pre})
    else $error("tick spacing wrong");
  AST_TICK_LATE: assert property (seen_t && pre > 16'h0001 |-> gap_t <= {1'b0, pre})
    else $error("tick missing");
endmodule : spw_chk

bind spw_top spw_chk u_chk (
  .clock_in(clock_in), .rst_n_in(rst_n_in), .reg_addr_in(reg_addr_in),
  .reg_write_in(reg_write_in), .reg_read_in(reg_read_in), .reg_wdata_in(reg_wdata_in),
  .reg_rdata_out(reg_rdata_out), .sync_enable_in(sync_enable_in),
  .sync_b_independent_select_in(sync_b_independent_select_in),
  .sync_high_width_in(sync_high_width_in), .activation_event_in(activation_event_in),
  .sync_out_a_out(sync_out_a_out), .sync_out_b_out(sync_out_b_out),
  .sync_active_out(sync_active_out), .wd_tick_out(wd_tick_out)
);

// *** testbench/testbench.sv ***
// Purpose: Self-checking bench for the sync timing and watchdog tick block
// Assumes: Inputs change on the falling clock edge
// Notes:   Prescale is cut to 4 by a register write to keep the run short
`timescale 1ns/100ps
module testbench;
  logic        clock_in = 1'b0;
  logic        rst_n_in = 1'b0;
  logic [11:0] reg_addr_in = 12'h000;
  logic        reg_write_in = 1'b0;
  logic        reg_read_in = 1'b0;
  logic [31:0] reg_wdata_in = 32'h0000_0000;
  logic [31:0] reg_rdata_out;
  logic        sync_enable_in = 1'b0;
  logic        sync_b_independent_select_in = 1'b0;
  logic [31:0] sync_high_width_in = 32'h0000_0000;
  logic        activation_event_in = 1'b0;
  logic        sync_out_a_out, sync_out_b_out, sync_active_out, wd_tick_out;
  int          err_count = 0;
  int          total_checks = 0;
  typedef struct packed {
    logic        wr;
    logic [11:0] addr;
    logic [31:0] data;
    logic [31:0] exp;
  } spw_row_type;
  // Unmapped write must not disturb the mapped word read last
  spw_row_type rows [7] = '{
    '{1'b1, 12'h114, 32'h0000_0005, 32'h0000_0005},
    '{1'b1, 12'h118, 32'h0000_0003, 32'h0000_0003},
    '{1'b1, 12'h11c, 32'h0000_0002, 32'h0000_0002},
    '{1'b1, 12'h200, 32'hffff_0007, 32'h0000_0007},
    '{1'b0, 12'h300, 32'h0000_0000, 32'h0000_0000},
    '{1'b1, 12'h300, 32'h0000_1234, 32'h0000_0000},
    '{1'b0, 12'h114, 32'h0000_0000, 32'h0000_0005}};

  spw_top u_dut (
    .clock_in(clock_in), .rst_n_in(rst_n_in), .reg_addr_in(reg_addr_in),
    .reg_write_in(reg_write_in), .reg_read_in(reg_read_in), .reg_wdata_in(reg_wdata_in),
    .reg_rdata_out(reg_rdata_out), .sync_enable_in(sync_enable_in),
    .sync_b_independent_select_in(sync_b_independent_select_in),
    .sync_high_width_in(sync_high_width_in), .activation_event_in(activation_event_in),
    .sync_out_a_out(sync_out_a_out), .sync_out_b_out(sync_out_b_out),
    .sync_active_out(sync_active_out), .wd_tick_out(wd_tick_out));

  initial begin
    forever #10 clock_in = ~clock_in;
  end

  task automatic conclude();
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : conclude

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(negedge clock_in);
    reg_addr_in = a;
    reg_wdata_in = d;
    reg_write_in = 1'b1;
    @(negedge clock_in);
    reg_write_in = 1'b0;
  endtask : wr

  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    @(negedge clock_in);
    reg_addr_in = a;
    reg_read_in = 1'b1;
    @(negedge clock_in);
    reg_read_in = 1'b0;
    chk("register read", exp, reg_rdata_out);
  endtask : rd

  function automatic logic pick(input int s);
    case (s)
      0: pick = sync_out_a_out;
      1: pick = sync_out_b_out;
      default: pick = wd_tick_out;
    endcase
  endfunction : pick

  // h counts cycles still high, c all cycles up to the next rise
  task automatic nxt(input int s, output int c, output int h);
    c = 0;
    while (pick(s) === 1'b1 && c < 500) begin
      @(negedge clock_in);
      c++;
    end
    h = c;
    while (pick(s) !== 1'b1 && c < 500) begin
      @(negedge clock_in);
      c++;
    end
    if (c >= 500) begin
      err_count++;
      $display("[ERR] edge wait expected rise seen none");
      conclude();
    end
  endtask : nxt

  task automatic arm(input logic ind, input logic [31:0] w);
    @(negedge clock_in);
    sync_b_independent_select_in = ind;
    sync_high_width_in = w;
    sync_enable_in = 1'b1;
    activation_event_in = 1'b1;
    @(negedge clock_in);
    activation_event_in = 1'b0;
  endtask : arm

  initial begin
    int c;
    int h;
    repeat (8) @(negedge clock_in);
    rst_n_in = 1'b1;
    for (int i = 0; i < 7; i++) begin
      if (rows[i].wr) wr(rows[i].addr, rows[i].data);
      rd(rows[i].addr, rows[i].exp);
    end
    $display("end register rows");
    wr(12'h200, 32'h0000_0004);
    nxt(2, c, h);
    chk("tick after restart", 32'h0000_0004, c);
    nxt(2, c, h);
    chk("tick gap disabled", 32'h0000_0004, c);
    $display("end watchdog tick");
    rst_n_in = 1'b0;
    repeat (8) @(negedge clock_in);
    rst_n_in = 1'b1;
    rd(12'h114, 32'h0000_0001);
    rd(12'h118, 32'h0000_0000);
    rd(12'h11c, 32'h0000_0000);
    rd(12'h200, 32'h0000_4e20);
    $display("end reset values");
    wr(12'h114, 32'h0000_0005);
    wr(12'h118, 32'h0000_0002);
    wr(12'h11c, 32'h0000_0003);
    arm(1'b0, 32'h0000_0001);
    chk("active", 32'h0000_0001, 32'(sync_active_out));
    nxt(0, c, h);
    chk("start delay", 32'h0000_0004, c);
    nxt(0, c, h);
    chk("a width", 32'h0000_0002, h);
    chk("a period", 32'h0000_0006, c);
    nxt(1, c, h);
    chk("b delay", 32'h0000_0002, c);
    nxt(0, c, h);
    sync_enable_in = 1'b0;
    @(negedge clock_in);
    chk("a cut", 32'h0000_0000,
        32'({sync_out_a_out, sync_out_b_out, sync_active_out}));
    sync_enable_in = 1'b1;
    h = 0;
    repeat (12) begin
      @(negedge clock_in);
      h = h + int'(sync_out_a_out !== 1'b0);
    end
    chk("no restart", 32'h0000_0000, h);
    sync_enable_in = 1'b0;
    $display("end dependent sync");
    wr(12'h118, 32'h0000_0003);
    arm(1'b1, 32'h0000_0000);
    nxt(0, c, h);
    chk("b with first a", 32'h0000_0001, 32'(sync_out_b_out));
    nxt(1, c, h);
    chk("b period", 32'h0000_0004, c);
    chk("b width", 32'h0000_0001, h);
    sync_enable_in = 1'b0;
    $display("end independent sync");
    wr(12'h118, 32'h0000_0000);
    arm(1'b0, 32'h0000_0000);
    nxt(0, c, h);
    chk("b with a, no delay", 32'h0000_0001, 32'(sync_out_b_out));
    sync_enable_in = 1'b0;
    $display("end zero delay sync");
    conclude();
  end
endmodule : testbench
